// *** rtl/crt_recovery.sv ***
// Clock recovery trim controller with a classic Wishbone register slave.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module crt_recovery (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sync_pin_i,
	input  wire logic        sync_xtal_i,
	input  wire logic        sync_sof_i,
	output logic      [5:0]  trim_o,
	output logic             irq_o
);

	crt_pkg::crt_state_t q;
	crt_pkg::crt_state_t next_q;
	logic        req;
	logic        wr;
	logic        raw;
	logic        lvl;
	logic        edge_evt;
	logic [6:0]  dmask;
	logic        sync_evt;
	logic [15:0] err_lim;
	logic [15:0] warn_lim;
	logic [15:0] tol_lim;
	logic [1:0]  step;
	logic [6:0]  adj;
	logic [31:0] rd;

	////////////////////////////////////////////////////////////////////////////
	// Add or subtract a step, saturating at the code limits; bit 6 flags it.
	function automatic logic [6:0] crt_trim_step(input logic [5:0] t,
			input logic [1:0] s, input logic inc);
		logic [6:0] w;
		w = inc ? ({1'b0, t} + {5'h00, s}) : ({1'b0, t} - {5'h00, s});
		if (inc && (w > {1'b0, crt_pkg::TRIM_MAX})) begin
			return {1'b1, crt_pkg::TRIM_MAX};
		end
		if (!inc && w[6]) begin
			return 7'h40;
		end
		return {1'b0, w[5:0]};
	endfunction : crt_trim_step

	////////////////////////////////////////////////////////////////////////////
	// Limits derived from the frequency error limit field.
	assign err_lim  = {1'b0, q.limit, 7'h00};
	assign warn_lim = 16'({q.limit, 1'b0}) + 16'(q.limit);
	assign tol_lim  = {8'h00, q.limit};

	// Bus request decode; every request is answered one cycle later.
	assign req = wb_cyc_i && wb_stb_i && !q.ack;
	assign wr  = req && wb_we_i;

	// Source mux; code 3 selects nothing and stays low.
	always_comb begin
		case (q.src)
			crt_pkg::SRC_PIN:  raw = sync_pin_i;
			crt_pkg::SRC_XTAL: raw = sync_xtal_i;
			crt_pkg::SRC_SOF:  raw = sync_sof_i;
			default:           raw = 1'b0;
		endcase
	end

	// Polarity after the filter, edge pulse, then the binary prescaler.
	assign lvl      = q.filt ^ q.pol;
	assign edge_evt = lvl && !q.lvl_prev;
	assign dmask    = 7'((8'h01 << q.div) - 8'h01);
	assign sync_evt = (edge_evt && ((q.div_cnt | ~dmask) == 7'h7F)) || q.sw_pend;

	////////////////////////////////////////////////////////////////////////////
	// Read data for the addressed register; unmapped reads give zero.
	always_comb begin
		rd = 32'h0000_0000;
		case (wb_adr_i)
			crt_pkg::ADR_CONTROL: begin
				rd[crt_pkg::CR_TRIM_LSB +: 6] = q.trim;
				rd[crt_pkg::CR_AUTO]          = q.auto_trim;
				rd[crt_pkg::CR_CEN]           = q.cen;
				rd[3:0]                       = q.irq_en;
			end
			crt_pkg::ADR_CONFIG: begin
				rd[crt_pkg::CFG_POL]              = q.pol;
				rd[crt_pkg::CFG_SRC_LSB +: 2]     = q.src;
				rd[crt_pkg::CFG_DIV_LSB +: 3]     = q.div;
				rd[crt_pkg::CFG_LIM_LSB +: 8]     = q.limit;
				rd[15:0]                          = q.reload;
			end
			crt_pkg::ADR_STATUS: begin
				rd[crt_pkg::ST_CAP_LSB +: 16] = q.cap;
				rd[crt_pkg::ST_DIR]           = q.cap_dir;
				rd[crt_pkg::ST_OVF]           = q.ovf;
				rd[crt_pkg::ST_MISS]          = q.miss;
				rd[crt_pkg::ST_SERR]          = q.serr;
				rd[3:0]                       = q.flags;
			end
			default: rd = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus writes first, then hardware events so a set beats a clear.
	always_comb begin
		next_q       = q;
		step         = 2'h0;
		adj          = {1'b0, q.trim};
		next_q.ack   = req;
		next_q.rdata = req ? rd : q.rdata;
		next_q.sw_pend = 1'b0;
		// Register writes.
		if (wr && (wb_adr_i == crt_pkg::ADR_CONTROL)) begin
			if (wb_sel_i[0]) begin
				next_q.auto_trim = wb_dat_i[crt_pkg::CR_AUTO];
				next_q.cen       = wb_dat_i[crt_pkg::CR_CEN];
				next_q.irq_en    = wb_dat_i[3:0];
				next_q.sw_pend   = wb_dat_i[crt_pkg::CR_SOFTWARE_SYNC];
			end
			if (wb_sel_i[1] && !q.auto_trim) begin
				next_q.trim = wb_dat_i[crt_pkg::CR_TRIM_LSB +: 6];
			end
		end
		if (wr && (wb_adr_i == crt_pkg::ADR_CONFIG) && !q.cen) begin
			if (wb_sel_i[3]) begin
				next_q.pol = wb_dat_i[crt_pkg::CFG_POL];
				next_q.src = wb_dat_i[crt_pkg::CFG_SRC_LSB +: 2];
			end
			if (wb_sel_i[3]) begin
				next_q.div = wb_dat_i[crt_pkg::CFG_DIV_LSB +: 3];
			end
			if (wb_sel_i[2]) begin
				next_q.limit = wb_dat_i[crt_pkg::CFG_LIM_LSB +: 8];
			end
			if (wb_sel_i[1]) begin
				next_q.reload[15:8] = wb_dat_i[15:8];
			end
			if (wb_sel_i[0]) begin
				next_q.reload[7:0] = wb_dat_i[7:0];
			end
		end
		if (wr && (wb_adr_i == crt_pkg::ADR_CLEAR) && wb_sel_i[0]) begin
			next_q.flags = q.flags & ~wb_dat_i[3:0];
			if (wb_dat_i[crt_pkg::FL_ERR]) begin
				next_q.ovf  = 1'b0;
				next_q.miss = 1'b0;
				next_q.serr = 1'b0;
			end
		end
		// Glitch filter: the level only follows a steady run of samples.
		next_q.filt_sh = {q.filt_sh[crt_pkg::FILT_LEN-2:0], raw};
		if (&q.filt_sh) begin
			next_q.filt = 1'b1;
		end else if (~|q.filt_sh) begin
			next_q.filt = 1'b0;
		end
		next_q.lvl_prev = lvl;
		if (edge_evt) begin
			next_q.div_cnt = q.div_cnt + 7'h01;
		end
		// Frequency error counter and evaluation.
		if (!q.cen) begin
			next_q.stopped = 1'b0;
		end else if (sync_evt) begin
			next_q.cnt     = q.reload;
			next_q.cnt_up  = 1'b0;
			next_q.stopped = 1'b0;
			next_q.cap     = q.cnt;
			next_q.cap_dir = q.cnt_up;
			if (q.stopped) begin
				next_q.miss = 1'b1;
				next_q.flags[crt_pkg::FL_ERR] = 1'b1;
			end else if (q.cnt >= err_lim) begin
				next_q.serr = 1'b1;
				next_q.flags[crt_pkg::FL_ERR] = 1'b1;
			end else if (q.cnt >= warn_lim) begin
				next_q.flags[crt_pkg::FL_WARN] = 1'b1;
				step = 2'h2;
			end else if (q.cnt >= tol_lim) begin
				next_q.flags[crt_pkg::FL_OK] = 1'b1;
				step = 2'h1;
			end else begin
				next_q.flags[crt_pkg::FL_OK] = 1'b1;
			end
			// Slow oscillator (still counting down) raises the code.
			adj = crt_trim_step(q.trim, step, !q.cnt_up);
			if (q.auto_trim && (step != 2'h0)) begin
				next_q.trim = adj[5:0];
				if (adj[6]) begin
					next_q.ovf = 1'b1;
					next_q.flags[crt_pkg::FL_ERR] = 1'b1;
				end
			end
		end else if (!q.cnt_up) begin
			if (q.cnt == 16'h0000) begin
				next_q.cnt_up = 1'b1;
				next_q.cnt    = 16'h0001;
				next_q.flags[crt_pkg::FL_EXPECTED_SYNC_EVENT] = 1'b1;
			end else begin
				next_q.cnt = q.cnt - 16'h0001;
			end
		end else if (q.cnt >= err_lim) begin
			if (!q.stopped) begin
				next_q.stopped = 1'b1;
				next_q.miss    = 1'b1;
				next_q.flags[crt_pkg::FL_ERR] = 1'b1;
			end
		end else begin
			next_q.cnt = q.cnt + 16'h0001;
		end
		next_q.irq = |(q.flags & q.irq_en);
		// Synchronous reset values.
		if (rst_i) begin
			next_q        = '0;
			next_q.trim   = crt_pkg::TRIM_RST;
			next_q.limit  = crt_pkg::LIMIT_RST;
			next_q.reload = crt_pkg::RELOAD_RST;
			next_q.src    = crt_pkg::SRC_RST;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		q <= next_q;
	end

	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;
	assign trim_o   = q.trim;
	assign irq_o    = q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the controller's behaviour.
	default clocking chk_clk @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_reload_on_sync: assert property (
		q.cen && sync_evt |=> q.cnt == $past(q.reload) && !q.cnt_up)
		else $error("counter not reloaded on sync");
	chk_expected_sync_event_at_zero: assert property (
		q.cen && !sync_evt && !q.cnt_up && q.cnt == 16'h0000
		|=> q.flags[crt_pkg::FL_EXPECTED_SYNC_EVENT] && q.cnt_up)
		else $error("expected sync not raised at zero");
	chk_stop_at_limit: assert property (
		q.cen && q.stopped |-> q.cnt == {1'b0, q.limit, 7'h00} && q.miss)
		else $error("counter stopped away from error limit");
	chk_capture_count: assert property (
		q.cen && sync_evt |=> q.cap == $past(q.cnt) && q.cap_dir == $past(q.cnt_up))
		else $error("capture mismatch");
	chk_warn_two_steps: assert property (
		q.cen && sync_evt && q.auto_trim && !q.stopped && !q.cnt_up
		&& q.cnt >= warn_lim && q.cnt < err_lim && q.trim < 6'h3E
		|=> q.trim == $past(q.trim) + 6'h02 && q.flags[crt_pkg::FL_WARN])
		else $error("warning step wrong");
	chk_trim_saturate: assert property (
		q.cen && sync_evt && q.auto_trim && !q.stopped && !q.cnt_up
		&& q.cnt >= tol_lim && q.cnt < err_lim && q.trim == crt_pkg::TRIM_MAX
		|=> q.ovf && q.trim == crt_pkg::TRIM_MAX)
		else $error("trim not saturated");
	chk_trim_locked: assert property (
		q.auto_trim && !(q.cen && sync_evt) |=> q.trim == $past(q.trim))
		else $error("trim changed under auto trim");
	chk_config_locked: assert property (
		q.cen |=> $stable(q.reload) && $stable(q.limit) && $stable(q.src))
		else $error("config changed while counter enabled");
	chk_error_flag: assert property (
		$rose(q.ovf) || $rose(q.miss) || $rose(q.serr) |-> q.flags[crt_pkg::FL_ERR])
		else $error("error flag not set");
	chk_ok_clear: assert property (
		wr && wb_adr_i == crt_pkg::ADR_CLEAR && wb_sel_i[0] && wb_dat_i[0]
		&& !(q.cen && sync_evt) |=> !q.flags[crt_pkg::FL_OK])
		else $error("sync ok flag not cleared");
	chk_ack_single: assert property (
		q.ack |=> !q.ack)
		else $error("ack held longer than one cycle");

endmodule : crt_recovery

// *** rtl/crt_pkg.sv ***
// Constants and types shared by the clock recovery trim controller.
package crt_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADR_CONTROL = 8'h00;
	localparam logic [7:0] ADR_CONFIG  = 8'h04;
	localparam logic [7:0] ADR_STATUS  = 8'h08;
	localparam logic [7:0] ADR_CLEAR   = 8'h0C;
	// Control field positions.
	localparam int CR_TRIM_LSB = 8;
	localparam int CR_SOFTWARE_SYNC   = 7;
	localparam int CR_AUTO     = 6;
	localparam int CR_CEN      = 5;
	// Config field positions.
	localparam int CFG_POL     = 31;
	localparam int CFG_SRC_LSB = 28;
	localparam int CFG_DIV_LSB = 24;
	localparam int CFG_LIM_LSB = 16;
	// Status field positions; flags sit in bits 3..0.
	localparam int ST_CAP_LSB = 16;
	localparam int ST_DIR     = 15;
	localparam int ST_OVF     = 10;
	localparam int ST_MISS    = 9;
	localparam int ST_SERR    = 8;
	localparam int FL_EXPECTED_SYNC_EVENT   = 3;
	localparam int FL_ERR     = 2;
	localparam int FL_WARN    = 1;
	localparam int FL_OK      = 0;
	// Reset values and the largest trim code.
	localparam logic [5:0]  TRIM_RST   = 6'h20;
	localparam logic [7:0]  LIMIT_RST  = 8'h22;
	localparam logic [15:0] RELOAD_RST = 16'hBB7F;
	localparam logic [1:0]  SRC_RST    = 2'h2;
	localparam logic [5:0]  TRIM_MAX   = 6'h3F;
	// Sync source codes.
	localparam logic [1:0] SRC_PIN  = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam logic [1:0] SRC_SOF  = 2'h2;
	// Glitch filter: a level must be seen this many samples in a row.
	localparam int FILT_LEN = 3;
	// Whole register state of the controller.
	typedef struct packed {
		logic [5:0]          trim;
		logic                auto_trim;
		logic                cen;
		logic [3:0]          irq_en;
		logic                pol;
		logic [1:0]          src;
		logic [2:0]          div;
		logic [7:0]          limit;
		logic [15:0]         reload;
		logic [15:0]         cap;
		logic                cap_dir;
		logic                ovf;
		logic                miss;
		logic                serr;
		logic [3:0]          flags;
		logic [15:0]         cnt;
		logic                cnt_up;
		logic                stopped;
		logic [FILT_LEN-1:0] filt_sh;
		logic                filt;
		logic                lvl_prev;
		logic [6:0]          div_cnt;
		logic                sw_pend;
		logic                ack;
		logic [31:0]         rdata;
		logic                irq;
	} crt_state_t;
endpackage : crt_pkg

// *** tb/crt_sync_model.sv ***
// Behavioural sync pulse source that stands in front of the recovery block.
`timescale 1ns/10ps
module crt_sync_model (
	input  wire logic       clk_i,
	input  wire logic       fire_i,
	input  wire logic [1:0] sel_i,
	input  wire logic [3:0] width_i,
	output logic            pin_o,
	output logic            xtal_o,
	output logic            sof_o
);
	logic [3:0] left = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Holds a pulse high for the requested number of clock cycles.
	always @(posedge clk_i) begin
		if (fire_i) begin
			left <= width_i;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end

	// Only the selected line carries pulses; idle lines rest low.
	assign pin_o  = (left != 4'h0) && (sel_i == 2'h0);
	assign xtal_o = (left != 4'h0) && (sel_i == 2'h1);
	assign sof_o  = (left != 4'h0) && (sel_i == 2'h2);
endmodule : crt_sync_model

// *** tb/tb.sv ***
// Self-checking testbench for the clock recovery trim controller.
`timescale 1ns/10ps
module tb;
	localparam int RLD = 300;
	localparam int LIM = 8;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] wb_dat;
	logic        wb_ack;
	logic        fire = 1'b0;
	logic [3:0]  wid = 4'h0;
	logic [1:0]  src = 2'h0;
	logic        s_pin;
	logic        s_xtal;
	logic        s_sof;
	logic [5:0]  trim_o;
	logic        irq_o;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	crt_recovery dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat),
		.wb_ack_o(wb_ack), .sync_pin_i(s_pin), .sync_xtal_i(s_xtal), .sync_sof_i(s_sof),
		.trim_o(trim_o), .irq_o(irq_o));
	crt_sync_model far (.clk_i(clk_i), .fire_i(fire), .sel_i(src), .width_i(wid),
		.pin_o(s_pin), .xtal_o(s_xtal), .sof_o(s_sof));

	////////////////////////////////////////////////////////////////////////////////
	// Clock generation and a cycle ceiling that cuts a hung run short.
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One classic bus cycle; the request holds until ack is sampled high on a rising edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			num_errors++;
			end_of_test();
		end
		rdat = wb_dat;
		{cyc, stb} <= 2'b00;
	endtask : wb

	task automatic pulse(input logic [3:0] w);
		@(posedge clk_i);
		fire <= 1'b1;
		wid <= w;
		@(posedge clk_i);
		fire <= 1'b0;
	endtask : pulse

	// Two software syncs gap cycles apart from trim t; checks class, trim and capture.
	task automatic meas(input int gap, input logic [5:0] t);
		logic up;
		logic miss;
		int   e;
		int   d;
		int   v;
		up = gap > RLD;
		e = up ? gap - RLD : RLD - gap;
		miss = e >= 128 * LIM;
		d = (e < LIM || miss) ? 0 : (e < 3 * LIM) ? 1 : 2;
		v = up ? int'(t) - d : int'(t) + d;
		wb(1'b1, crt_pkg::ADR_CONTROL, {18'h0, t, 8'hAF}, 4'hF);
		wb(1'b1, crt_pkg::ADR_CLEAR, 32'h0000_000F, 4'h1);
		repeat (gap - 6) @(posedge clk_i);
		wb(1'b1, crt_pkg::ADR_CONTROL, {18'h0, t, 8'hEF}, 4'hF);
		repeat (4) @(posedge clk_i);
		chk(32'(irq_o), 32'h1);
		wb(1'b0, crt_pkg::ADR_STATUS, 32'h0, 4'hF);
		chk(32'(rdat[3:0]), 32'({up, miss || v > 63 || v < 0, !miss && e >= 3 * LIM,
			e < 3 * LIM}));
		chk(32'(rdat[10:9]), 32'({v > 63 || v < 0, miss}));
		chk(32'(trim_o), 32'(v > 63 ? 63 : v < 0 ? 0 : v));
		if (!miss) chk(32'(rdat[31:16] + 16'd2 - 16'(e) <= 16'd4), 32'h1);
		wb(1'b1, crt_pkg::ADR_CLEAR, 32'h0000_000F, 4'h1);
		wb(1'b0, crt_pkg::ADR_STATUS, 32'h0, 4'hF);
		chk(32'(rdat[10:0]), 32'h0);
		chk(32'(irq_o), 32'h0);
	endtask : meas

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, register access, measurements, hardware sources.
	initial begin
		logic [5:0] t;
		logic       pol;
		int         c;
		int         m;
		void'($urandom(32'h38F4_6901));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, crt_pkg::ADR_CONTROL, 32'h0, 4'hF);
		chk(rdat, 32'h0000_2000);
		wb(1'b0, crt_pkg::ADR_CONFIG, 32'h0, 4'hF);
		chk(rdat, 32'h2022_BB7F);
		wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
		wb(1'b0, 8'h10, 32'h0, 4'hF);
		chk(rdat, 32'h0);
		t = 6'($urandom);
		wb(1'b1, crt_pkg::ADR_CONTROL, {18'h0, t, 8'h0F}, 4'h2);
		wb(1'b0, crt_pkg::ADR_CONTROL, 32'h0, 4'hF);
		chk(rdat, {18'h0, t, 8'h00});
		chk(32'(trim_o), 32'(t));
		wb(1'b1, crt_pkg::ADR_CONFIG, 32'h0008_012C, 4'hF);
		wb(1'b1, crt_pkg::ADR_CONTROL, 32'h0000_206F, 4'hF);
		wb(1'b1, crt_pkg::ADR_CONFIG, 32'h0000_0000, 4'hF);
		wb(1'b0, crt_pkg::ADR_CONFIG, 32'h0, 4'hF);
		chk(rdat, 32'h0008_012C);
		wb(1'b1, crt_pkg::ADR_CONTROL, 32'h0000_056F, 4'hF);
		wb(1'b0, crt_pkg::ADR_CONTROL, 32'h0, 4'hF);
		chk(rdat, 32'h0000_206F);
		meas(RLD - 50, 6'h3F);
		meas(RLD + 50, 6'h00);
		meas(RLD + 1200, 6'h20);
		repeat (10) begin
			c = int'($urandom % 4);
			m = (c == 0) ? 4 : (c == 1) ? 11 + int'($urandom % 10) :
				(c == 2) ? 30 + int'($urandom % 200) : 1100;
			meas((c == 3 || (c != 0 && $urandom % 2 == 1)) ? RLD + m : RLD - m, 6'($urandom));
		end
		for (int s = 0; s < 3; s++) begin
			pol = 1'($urandom);
			wb(1'b1, crt_pkg::ADR_CONTROL, 32'h0000_000F, 4'hF);
			wb(1'b1, crt_pkg::ADR_CONFIG, {pol, 1'b0, 2'(s), 28'h008_012C}, 4'hF);
			wb(1'b1, crt_pkg::ADR_CONTROL, 32'h0000_202F, 4'hF);
			src <= 2'(s);
			pulse(4'h4);
			repeat (100) @(posedge clk_i);
			wb(1'b1, crt_pkg::ADR_CLEAR, 32'h0000_000F, 4'h1);
			pulse(4'h1);
			repeat (189) @(posedge clk_i);
			pulse(4'h4);
			repeat (20) @(posedge clk_i);
			wb(1'b0, crt_pkg::ADR_STATUS, 32'h0, 4'hF);
			chk(32'(rdat[3:0]), 32'h1);
			chk(32'(rdat[31:16] + 16'd2 - 16'd4 <= 16'd4), 32'h1);
		end
		end_of_test();
	end
endmodule : tb
